//--- rtl/plcsr_pkg.sv
package plcsr_pkg;
  // Configuration offsets of the three link words
  localparam logic [11:0] LINK_CTRL_OFS   = 12'h0A0;
  localparam logic [11:0] LINK_STATUS_OFS = 12'h0A2;
  localparam logic [11:0] LINK_CAP_OFS    = 12'h09C;

  // Link control field positions
  localparam int CTL_CLK_PM_BIT   = 8;
  localparam int CTL_EXT_SYNCH    = 7;
  localparam int CTL_COMMON_CLK   = 6;
  localparam int CTL_RETRAIN_BIT  = 5;
  localparam int CTL_DISABLE_BIT  = 4;
  localparam int CTL_RCB_BIT      = 3;
  localparam int CTL_ASPM_LSB     = 0;
  // Writable bits: 8,7,6,3,1:0; all others discarded
  localparam logic [15:0] CTL_WRITE_MASK = 16'h01CB;
  localparam logic [15:0] CTL_RESET      = 16'h0000;

  // Link status fixed fields
  localparam int             STS_SLOT_CLK_BIT = 12;
  localparam logic [5:0]     STS_WIDTH_X1     = 6'h01;
  localparam logic [3:0]     STS_SPEED_2G5    = 4'h1;

  // Link capability: clock PM support bit
  localparam int CAP_CLK_PM_BIT = 18;

  // Active-state PM encodings
  localparam logic [1:0] ASPM_OFF  = 2'h0;
  localparam logic [1:0] ASPM_L0S  = 2'h1;
  localparam logic [1:0] ASPM_L1   = 2'h2;
  localparam logic [1:0] ASPM_BOTH = 2'h3;

  // Exit latency codes per clock mode
  localparam logic [2:0] L0S_LAT_COMMON = 3'h3;
  localparam logic [2:0] L0S_LAT_ASYNC  = 3'h4;

  // Config read/write request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [15:0] wdata;
  } plcsr_req_s;

  // Link-facing controls
  typedef struct packed {
    logic       ext_synch;
    logic       allow_l0s;
    logic       allow_l1;
    logic [2:0] l0s_latency;
    logic [2:0] l1_latency;
  } plcsr_link_s;
endpackage

//--- rtl/plcsr_regs.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Link control bits 15:9 always read zero.
// - Clock-request output held low while clock PM enable is clear, released when set.
// - Extended synch bit set asks the link for longer FTS and an extra TS2 on L1 exit.
// - Common clock bit selects which exit latency values are reported.
// - Retrain and disable bits of link control do nothing and read zero.
// - Completion boundary bit is stored only; own boundary stays fixed at 128 bytes.
// - Link control bit 2 reads zero.
// - Active-state PM field gates L0s and L1 entry permission.
// - Link status word is read-only; writes leave it unchanged.
// - Link status bits 15:13 read zero.
// - Slot clock bit reports 1 on common 100 MHz reference, 0 on independent 125 MHz.
// - Link training and retrain status bits read zero.
// - Negotiated width field reads one lane.
// - Current speed field reads 2.5 Gb/s.
// - Link capability bit 18 is hardwired to one.
module plcsr_regs (
  input  wire logic                       clk,           // 250 MHz clock
  input  wire logic                       rst_n,         // Fundamental reset, active low
  input  wire plcsr_pkg::plcsr_req_s      req,           // Config read/write request
  input  wire logic                       common_refclk, // Strap: common 100 MHz refclk
  input  wire logic [2:0]                 l1_lat_common, // L1 exit latency, common clock
  input  wire logic [2:0]                 l1_lat_async,  // L1 exit latency, async clock
  output logic [31:0]                     rdata,         // Registered read data
  output logic                            rvalid,        // Read data valid pulse
  output logic                            clkreq_n,      // Clock request, low holds refclk
  output plcsr_pkg::plcsr_link_s          link_ctl,      // Controls toward link layer
  output logic                            rcb_128        // Own completion boundary fixed
);

  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic        strap_meta_reg;
  logic        strap_reg;
  logic [15:0] status_word;
  logic [31:0] cap_word;

  //////////////////////////////////////////////////////////////////////////////
  // Strap passes two flops before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta_reg <= 1'b0;
      strap_reg      <= 1'b0;
    end else begin
      strap_meta_reg <= common_refclk;
      strap_reg      <= strap_meta_reg;
    end
  end

  // Fixed status word; no write path exists at all
  always_comb begin
    status_word = 16'h0000;
    status_word[plcsr_pkg::STS_SLOT_CLK_BIT] = strap_reg;
    status_word[9:4] = plcsr_pkg::STS_WIDTH_X1;
    status_word[3:0] = plcsr_pkg::STS_SPEED_2G5;
  end

  // Capability word carries only the clock PM flag here
  always_comb begin
    cap_word = 32'h0000_0000;
    cap_word[plcsr_pkg::CAP_CLK_PM_BIT] = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Masked write keeps reserved and read-only bits at zero
  always_comb begin
    ctrl_next = ctrl_reg;
    if (req.wr && req.addr == plcsr_pkg::LINK_CTRL_OFS) begin
      ctrl_next = req.wdata & plcsr_pkg::CTL_WRITE_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= plcsr_pkg::CTL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read strobe echoed one edge later, so software knows rdata is fresh
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
    end
  end

  // Read mux follows the address every cycle; status writes fall through untouched
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else begin
      unique case (req.addr)
        plcsr_pkg::LINK_CTRL_OFS:   rdata <= {16'h0000, ctrl_reg};
        plcsr_pkg::LINK_STATUS_OFS: rdata <= {16'h0000, status_word};
        plcsr_pkg::LINK_CAP_OFS:    rdata <= cap_word;
        default:                    rdata <= 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock request: low keeps refclk running, released only with clock PM enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkreq_n <= 1'b0;
    end else begin
      clkreq_n <= ctrl_reg[plcsr_pkg::CTL_CLK_PM_BIT];
    end
  end

  // Link-side controls, registered so the link layer sees clean levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_ctl <= '0;
    end else begin
      link_ctl.ext_synch <= ctrl_reg[plcsr_pkg::CTL_EXT_SYNCH];
      link_ctl.allow_l0s <= ctrl_reg[plcsr_pkg::CTL_ASPM_LSB];
      link_ctl.allow_l1  <= ctrl_reg[plcsr_pkg::CTL_ASPM_LSB+1];
      link_ctl.l0s_latency <= ctrl_reg[plcsr_pkg::CTL_COMMON_CLK] ?
                              plcsr_pkg::L0S_LAT_COMMON : plcsr_pkg::L0S_LAT_ASYNC;
      link_ctl.l1_latency  <= ctrl_reg[plcsr_pkg::CTL_COMMON_CLK] ?
                              l1_lat_common : l1_lat_async;
    end
  end

  // Own completion boundary never follows the stored root complex value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcb_128 <= 1'b1;
    end else begin
      rcb_128 <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control word shape: only the writable fields may ever hold a one
  a_ctrl_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_reg & ~plcsr_pkg::CTL_WRITE_MASK) == 16'h0000)
    else $error("reserved link control bits set");
  a_ctrl_ro_bits: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_reg[plcsr_pkg::CTL_RETRAIN_BIT] == 1'b0 &&
    ctrl_reg[plcsr_pkg::CTL_DISABLE_BIT] == 1'b0)
    else $error("retrain or disable control bit nonzero");
  a_ctrl_bit_two: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_reg[2] == 1'b0)
    else $error("reserved control bit 2 nonzero");

  // Write path: masked data lands one edge after the strobe
  a_ctrl_write: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && req.addr == plcsr_pkg::LINK_CTRL_OFS |=>
      ctrl_reg == ($past(req.wdata) & plcsr_pkg::CTL_WRITE_MASK))
    else $error("control write not masked");
  // Any other write, status included, must leave the control word alone
  a_ctrl_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(req.wr && req.addr == plcsr_pkg::LINK_CTRL_OFS) |=> $stable(ctrl_reg))
    else $error("control word changed without a control write");

  // Status and capability reads return their fixed fields
  a_status_read: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && req.addr == plcsr_pkg::LINK_STATUS_OFS |=>
      rdata[31:13] == 19'h00000 && rdata[12] == $past(strap_reg) &&
      rdata[11:10] == 2'h0 && rdata[9:4] == plcsr_pkg::STS_WIDTH_X1 &&
      rdata[3:0] == plcsr_pkg::STS_SPEED_2G5)
    else $error("status word read wrong");
  a_cap_clkpm: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && req.addr == plcsr_pkg::LINK_CAP_OFS |=> rdata[18])
    else $error("clock pm capability missing");

  // Clock request follows the enable one edge behind
  a_clkreq_follow: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl_reg[plcsr_pkg::CTL_CLK_PM_BIT] |=> !clkreq_n)
    else $error("clkreq released while clock pm disabled");
  // Release is allowed, not demanded; this pins down the chosen behaviour
  a_clkreq_release: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_reg[plcsr_pkg::CTL_CLK_PM_BIT] |=> clkreq_n)
    else $error("clkreq held low while clock pm enabled");

  // Link-side controls track the control word one edge behind
  a_ext_synch: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 link_ctl.ext_synch == $past(ctrl_reg[plcsr_pkg::CTL_EXT_SYNCH]))
    else $error("extended synch not following control");
  // Exit latency codes switch with the common clock bit
  a_latency_sel: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_reg[plcsr_pkg::CTL_COMMON_CLK] |=>
      link_ctl.l0s_latency == plcsr_pkg::L0S_LAT_COMMON &&
      link_ctl.l1_latency == $past(l1_lat_common))
    else $error("wrong latency for common clock");
  a_latency_async: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl_reg[plcsr_pkg::CTL_COMMON_CLK] |=>
      link_ctl.l0s_latency == plcsr_pkg::L0S_LAT_ASYNC &&
      link_ctl.l1_latency == $past(l1_lat_async))
    else $error("wrong latency for asynchronous clock");
  // Own boundary stays put whatever the stored boundary bit holds
  a_rcb_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 rcb_128)
    else $error("completion boundary changed");

  // Each active-state PM code opens exactly the entries it names
  a_aspm_gate: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_reg[1:0] == plcsr_pkg::ASPM_OFF |=> !link_ctl.allow_l0s && !link_ctl.allow_l1)
    else $error("low power allowed while aspm off");
  a_aspm_l0s: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_reg[1:0] == plcsr_pkg::ASPM_L0S |=> link_ctl.allow_l0s && !link_ctl.allow_l1)
    else $error("aspm l0s code gates wrong entries");
  a_aspm_l1: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_reg[1:0] == plcsr_pkg::ASPM_L1 |=> !link_ctl.allow_l0s && link_ctl.allow_l1)
    else $error("aspm l1 code gates wrong entries");
  a_aspm_both: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_reg[1:0] == plcsr_pkg::ASPM_BOTH |=> link_ctl.allow_l0s && link_ctl.allow_l1)
    else $error("aspm both code gates wrong entries");

  // Main scenarios worth seeing at least once
  c_clkpm_on: cover property (@(posedge clk) disable iff (!rst_n) clkreq_n);
  c_aspm_both: cover property (@(posedge clk) disable iff (!rst_n)
    link_ctl.allow_l0s && link_ctl.allow_l1);
  c_status_wr: cover property (@(posedge clk) disable iff (!rst_n)
    req.wr && req.addr == plcsr_pkg::LINK_STATUS_OFS);
  c_common_clk: cover property (@(posedge clk) disable iff (!rst_n)
    ctrl_reg[plcsr_pkg::CTL_COMMON_CLK]);
  c_ext_synch: cover property (@(posedge clk) disable iff (!rst_n)
    link_ctl.ext_synch);

endmodule

//--- tb/plcsr_rc_model.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module plcsr_rc_model #(
  parameter logic [2:0] LAT_COMMON = 3'h2,
  parameter logic [2:0] LAT_ASYNC  = 3'h5
) (
  input  wire logic       clk,           // System clock
  input  wire logic       clkreq_n,      // Clock request from device
  output logic [2:0]      l1_lat_common, // L1 exit code, common clock
  output logic [2:0]      l1_lat_async,  // L1 exit code, async clock
  output logic            refclk_on      // Refclk kept running
);
  // Distinct codes, so a swapped select cannot hide
  assign l1_lat_common = LAT_COMMON;
  assign l1_lat_async  = LAT_ASYNC;
  // Refclk stops only while the request is released
  always_ff @(posedge clk) begin
    refclk_on <= ~clkreq_n;
  end
endmodule

//--- tb/pcie_link_ctrl_status_regs_tb.sv
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module pcie_link_ctrl_status_regs_tb;
  logic                   clk = 0;
  logic                   rst_n = 0;
  logic                   strap = 1;
  plcsr_pkg::plcsr_req_s  req = '0;
  plcsr_pkg::plcsr_link_s lk;
  logic [2:0]             lc, la;
  logic [31:0]            rdata;
  logic                   rvalid, clkreq_n, rcb_128, refclk_on;
  int                     n_fail = 0;
  int                     compares = 0;
  localparam logic [11:0] CTL = plcsr_pkg::LINK_CTRL_OFS;
  localparam logic [11:0] STS = plcsr_pkg::LINK_STATUS_OFS;
  // Free-running 250 MHz clock
  always #2 clk = ~clk;
  plcsr_regs dut (.clk(clk), .rst_n(rst_n), .req(req), .common_refclk(strap),
    .l1_lat_common(lc), .l1_lat_async(la), .rdata(rdata), .rvalid(rvalid),
    .clkreq_n(clkreq_n), .link_ctl(lk), .rcb_128(rcb_128));
  plcsr_rc_model rc (.clk(clk), .clkreq_n(clkreq_n), .l1_lat_common(lc),
    .l1_lat_async(la), .refclk_on(refclk_on));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One-cycle write strobe, taken at the next rising edge
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge clk);
    req.wr = 1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 0;
  endtask
  // One-edge strobe; rvalid stands only until the following edge, rdata while the address is held
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    chk("rvalid", 32'h1, rvalid);
    chk("rdata", exp, rdata);
    req.rd = 1'b0;
  endtask
  task automatic stop_test;
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    chk("rcb_128", 32'h1, rcb_128);
    chk("clkreq_n", 32'h0, clkreq_n);
    rd(CTL, 32'h0000_0000);
    rd(STS, 32'h0000_1011);
    rd(plcsr_pkg::LINK_CAP_OFS, 32'h0004_0000);
    rd(12'h0B0, 32'h0000_0000);
    wr(CTL, 16'hFFFF);
    @(negedge clk);
    chk("clkreq_n", 32'h1, clkreq_n);
    chk("ext_synch", 32'h1, lk.ext_synch);
    rd(CTL, 32'h0000_01CB);
    chk("refclk_on", 32'h0, refclk_on);
    chk("rcb_128", 32'h1, rcb_128);
    // Every PM code, common clock bit following bit 0
    for (int k = 0; k < 4; k++) begin
      wr(CTL, {9'h000, k[0], 4'h0, k[1:0]});
      @(negedge clk);
      chk("allow_l0s", k[0], lk.allow_l0s);
      chk("allow_l1", k[1], lk.allow_l1);
      chk("l0s_lat", k[0] ? plcsr_pkg::L0S_LAT_COMMON : plcsr_pkg::L0S_LAT_ASYNC,
          lk.l0s_latency);
      chk("l1_lat", k[0] ? lc : la, lk.l1_latency);
      chk("clkreq_n", 32'h0, clkreq_n);
    end
    chk("refclk_on", 32'h1, refclk_on);
    wr(STS, 16'hFFFF);
    rd(STS, 32'h0000_1011);
    @(negedge clk) strap = 0;
    repeat (3) @(negedge clk);
    rd(STS, 32'h0000_0011);
    // Mid-run fundamental reset must bring back the control word, clock request, extended synch, boundary and L1 permission defaults
    wr(CTL, 16'hFFFF);
    @(negedge clk) rst_n = 1'b0;
    @(negedge clk);
    chk("clkreq_n", 32'h0, clkreq_n);
    chk("ext_synch", 32'h0, lk.ext_synch);
    chk("rcb_128", 32'h1, rcb_128);
    @(negedge clk) rst_n = 1'b1;
    rd(CTL, 32'h0000_0000);
    chk("allow_l1", 32'h0, lk.allow_l1);
    stop_test();
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    stop_test();
  end
endmodule
